// >>> tfdc_device.sv
// tfdc_device: driver-board digital control, latches, decoders and kick sequencer
// assumes strobes and data come from logic on clk; sweep and kick lines are pins
`timescale 1ns/10ps
`default_nettype none
module tfdc_device #(
  parameter int unsigned SEQ_CYC = tfdc_pkg::KICK_SEQ_CYC
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // link to host
  tfdc_if.device                         bus,
  // board pins
  input  wire logic                      sweep_active,
  input  wire logic [2:0]                band_code,
  input  wire logic                      oscillator_kick_active_n,
  // DAC words
  output var  logic [7:0]                delay_dac_word,
  output var  logic [7:0]                slope_dac_word,
  // analog switch controls
  output var  logic                      delay_comp_enable,
  output var  logic                      delay_comp_reset,
  output var  logic [7:0]                divider_tap_sel,
  output var  logic                      band_zero_park,
  output var  logic                      band_zero_path,
  output var  logic                      band_high_path,
  output var  logic                      hold_path_select,
  output var  logic                      track_sample,
  output var  logic                      multiplier_kick_active_n,
  output var  logic                      kick_start
);
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic              sweep_s;
  logic              okick_n_s;
  logic [2:0]        band_s;

  tfdc_sync #(.RST_VAL(1'b0)) u_sync_sweep (
    .clk (clk), .rst (rst), .d (sweep_active), .q (sweep_s)
  );
  tfdc_sync #(.RST_VAL(1'b1)) u_sync_okick (
    .clk (clk), .rst (rst), .d (oscillator_kick_active_n), .q (okick_n_s)
  );
  genvar gi;
  generate
    for (gi = 0; gi < tfdc_pkg::BAND_W; gi++) begin : g_band
      tfdc_sync #(.RST_VAL(1'b0)) u_sync_band (
        .clk (clk), .rst (rst), .d (band_code[gi]), .q (band_s[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // latches written from the bus
  logic [7:0]  delay_reg, delay_next;
  logic [7:0]  slope_reg, slope_next;
  logic        sh_reg, sh_next;
  logic        path_reg, path_next;
  logic        kick_reg, kick_next;

  always_comb begin
    delay_next = delay_reg;
    slope_next = slope_reg;
    sh_next    = sh_reg;
    path_next  = path_reg;
    kick_next  = kick_reg;
    if (bus.delay_dac_write_strobe) begin
      delay_next = bus.data_bus;
    end
    if (bus.slope_dac_write_strobe) begin
      slope_next = bus.data_bus;
    end
    if (bus.control_latch_write_strobe) begin
      sh_next   = bus.data_bus[tfdc_pkg::BIT_SH];
      path_next = bus.data_bus[tfdc_pkg::BIT_PATH];
      kick_next = bus.data_bus[tfdc_pkg::BIT_KICK];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      delay_reg <= 8'h00;
      slope_reg <= 8'h00;
      sh_reg    <= 1'b0;
      path_reg  <= 1'b0;
      kick_reg  <= 1'b0;
    end else begin
      delay_reg <= delay_next;
      slope_reg <= slope_next;
      sh_reg    <= sh_next;
      path_reg  <= path_next;
      kick_reg  <= kick_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // kick sequencer: positive then negative pulse, stand-in timing
  typedef enum logic [1:0] {K_IDLE, K_POS, K_NEG} tfdc_kick_t;
  tfdc_kick_t  kst_reg, kst_next;
  logic [15:0] kcnt_reg, kcnt_next;
  logic        kprev_reg, kprev_next;
  logic        kstart_reg, kstart_next;
  logic [15:0] half_cyc;

  assign half_cyc = 16'(SEQ_CYC / 2);

  always_comb begin
    kst_next    = kst_reg;
    kcnt_next   = kcnt_reg;
    kprev_next  = kick_reg;
    kstart_next = 1'b0;
    case (kst_reg)
      K_IDLE: begin
        if (kick_reg && !kprev_reg) begin
          kst_next    = K_POS;
          kcnt_next   = 16'h0000;
          kstart_next = 1'b1;
        end
      end
      K_POS: begin
        kcnt_next = kcnt_reg + 16'h0001;
        if (kcnt_reg + 16'h0001 >= half_cyc) begin
          kst_next  = K_NEG;
          kcnt_next = 16'h0000;
        end
      end
      K_NEG: begin
        kcnt_next = kcnt_reg + 16'h0001;
        if (kcnt_reg + 16'h0001 >= half_cyc) begin
          kst_next  = K_IDLE;
          kcnt_next = 16'h0000;
        end
      end
      default: begin
        kst_next = K_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      kst_reg    <= K_IDLE;
      kcnt_reg   <= 16'h0000;
      kprev_reg  <= 1'b0;
      kstart_reg <= 1'b0;
    end else begin
      kst_reg    <= kst_next;
      kcnt_reg   <= kcnt_next;
      kprev_reg  <= kprev_next;
      kstart_reg <= kstart_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decoders and switch controls, registered
  logic [7:0] tap_next, tap_reg;
  logic [7:0] outs_next, outs_reg;
  logic       mk_n;

  always_comb begin
    mk_n      = (kst_reg == K_IDLE);
    tap_next  = 8'h01 << band_s;
    outs_next = {
      mk_n,
      sh_reg & mk_n & okick_n_s,
      mk_n & okick_n_s,
      path_reg,
      (band_s != 3'h0),
      (band_s == 3'h0),
      !sweep_s,
      sweep_s
    };
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tap_reg  <= 8'h01;
      outs_reg <= 8'ha6;
    end else begin
      tap_reg  <= tap_next;
      outs_reg <= outs_next;
    end
  end

  assign delay_dac_word           = delay_reg;
  assign slope_dac_word           = slope_reg;
  assign divider_tap_sel          = tap_reg;
  assign delay_comp_enable        = outs_reg[0];
  assign delay_comp_reset         = outs_reg[1];
  assign band_zero_park           = outs_reg[2];
  assign band_zero_path           = outs_reg[2];
  assign band_high_path           = outs_reg[3];
  assign hold_path_select         = outs_reg[4];
  assign bus.kicks_done_status    = outs_reg[5];
  assign track_sample             = outs_reg[6];
  assign multiplier_kick_active_n = outs_reg[7];
  assign kick_start               = kstart_reg;
endmodule : tfdc_device
`default_nettype wire

// >>> tfdc_pkg.sv
// tfdc_pkg: constants shared by the driver-board control logic and its host end
// assumes a 20 MHz system clock and an 8-bit shared data bus
package tfdc_pkg;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned BAND_W        = 3;
  localparam int unsigned TAP_W         = 8;
  localparam int unsigned BIT_SH        = 3;
  localparam int unsigned BIT_PATH      = 4;
  localparam int unsigned BIT_KICK      = 5;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned KICK_US       = 20;
  localparam int unsigned KICK_CYC      = (KICK_US * (CLK_HZ / 1_000_000));
  localparam int unsigned TIMEOUT_MS    = 90;
  localparam int unsigned TIMEOUT_CYC   = (TIMEOUT_MS * (CLK_HZ / 1000));
  localparam int unsigned KICK_SEQ_CYC  = 200;
  // host register offsets
  localparam logic [3:0]  A_DELAY       = 4'h0;
  localparam logic [3:0]  A_SLOPE       = 4'h1;
  localparam logic [3:0]  A_CTRL        = 4'h2;
  localparam logic [3:0]  A_KICK        = 4'h3;
  localparam logic [3:0]  A_STATUS      = 4'h4;
  localparam logic [3:0]  A_BAND        = 4'h5;
  // host status bits
  localparam int unsigned ST_BUSY       = 0;
  localparam int unsigned ST_FAULT      = 1;
  localparam int unsigned ST_DONE       = 2;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
endpackage : tfdc_pkg

// >>> tfdc_if.sv
// tfdc_if: data bus, strobes and status lines between host and driver board
// assumes both ends on one clock
`timescale 1ns/10ps
`default_nettype none
interface tfdc_if;
  logic [7:0] data_bus;
  logic       delay_dac_write_strobe;
  logic       slope_dac_write_strobe;
  logic       control_latch_write_strobe;
  logic       kicks_done_status;
  modport device (
    input  data_bus, delay_dac_write_strobe, slope_dac_write_strobe,
    input  control_latch_write_strobe,
    output kicks_done_status
  );
  modport host (
    output data_bus, delay_dac_write_strobe, slope_dac_write_strobe,
    output control_latch_write_strobe,
    input  kicks_done_status
  );
endinterface : tfdc_if
`default_nettype wire

// >>> tfdc_sync.sv
// tfdc_sync: three-stage synchroniser for pin inputs
// assumes the input is asynchronous to clk; out changes when stages 2 and 3 agree
`timescale 1ns/10ps
`default_nettype none
module tfdc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // signal
  input  wire logic d,
  output var  logic q
);
  logic [2:0] s_reg;
  logic [2:0] s_next;
  logic       q_next;
  logic       q_reg;

  always_comb begin
    s_next = {s_reg[1:0], d};
    q_next = (s_reg[1] == s_reg[2]) ? s_reg[2] : q_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= {3{RST_VAL}};
      q_reg <= RST_VAL;
    end else begin
      s_reg <= s_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule : tfdc_sync
`default_nettype wire

// >>> tfdc_host.sv
// tfdc_host: host end, turns register writes into strobes and times kicks
// assumes software port on clk; read data valid the cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
module tfdc_host #(
  parameter int unsigned KICK_CYC    = tfdc_pkg::KICK_CYC,
  parameter int unsigned TIMEOUT_CYC = tfdc_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // software port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata,
  // link to device
  tfdc_if.host            bus
);
  typedef enum logic [1:0] {H_IDLE, H_HIGH, H_WAIT} tfdc_host_t;
  tfdc_host_t  st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [7:0]  data_reg, data_next;
  logic [2:0]  stb_reg, stb_next;
  logic        fault_reg, fault_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        done_s;
  logic        wr_kick;

  // same-clock register, taken direct so the wait never sees a stale high
  assign done_s = bus.kicks_done_status;

  assign wr_kick = wr && (addr == tfdc_pkg::A_KICK) && (st_reg == H_IDLE);

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    ctrl_next  = ctrl_reg;
    data_next  = data_reg;
    stb_next   = 3'h0;
    fault_next = fault_reg;
    rdata_next = 8'h00;
    if (wr && addr == tfdc_pkg::A_DELAY) begin
      data_next = wdata;
      stb_next  = 3'h1;
    end
    if (wr && addr == tfdc_pkg::A_SLOPE) begin
      data_next = wdata;
      stb_next  = 3'h2;
    end
    if (wr && addr == tfdc_pkg::A_CTRL) begin
      ctrl_next = wdata & ~(8'h01 << tfdc_pkg::BIT_KICK);
      data_next = ctrl_next;
      stb_next  = 3'h4;
    end
    case (st_reg)
      H_IDLE: begin
        if (wr_kick) begin
          fault_next = 1'b0;
          st_next    = H_HIGH;
          cnt_next   = 32'h0;
          data_next  = ctrl_reg | (8'h01 << tfdc_pkg::BIT_KICK);
          stb_next   = 3'h4;
        end
      end
      H_HIGH: begin
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg + 32'h1 >= KICK_CYC) begin
          st_next   = H_WAIT;
          cnt_next  = 32'h0;
          data_next = ctrl_reg;
          stb_next  = 3'h4;
        end
      end
      H_WAIT: begin
        cnt_next = cnt_reg + 32'h1;
        if (done_s) begin
          st_next = H_IDLE;
        end else if (cnt_reg + 32'h1 >= TIMEOUT_CYC) begin
          st_next    = H_IDLE;
          fault_next = 1'b1;
        end
      end
      default: begin
        st_next = H_IDLE;
      end
    endcase
    if (rd) begin
      case (addr)
        tfdc_pkg::A_CTRL:   rdata_next = ctrl_reg;
        tfdc_pkg::A_STATUS: rdata_next = {5'h00, done_s, fault_reg, (st_reg != H_IDLE)};
        default:            rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg    <= H_IDLE;
      cnt_reg   <= 32'h0;
      ctrl_reg  <= tfdc_pkg::CTRL_RST;
      data_reg  <= 8'h00;
      stb_reg   <= 3'h0;
      fault_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      ctrl_reg  <= ctrl_next;
      data_reg  <= data_next;
      stb_reg   <= stb_next;
      fault_reg <= fault_next;
      rdata_reg <= rdata_next;
    end
  end

  assign bus.data_bus                   = data_reg;
  assign bus.delay_dac_write_strobe     = stb_reg[0];
  assign bus.slope_dac_write_strobe     = stb_reg[1];
  assign bus.control_latch_write_strobe = stb_reg[2];
  assign rdata                          = rdata_reg;
endmodule : tfdc_host
`default_nettype wire

// >>> tfdc_link_monitor.sv
// tfdc_link_monitor: assertions on the host to device link
// assumes one clock domain, rst async active high
`timescale 1ns/10ps
`default_nettype none
module tfdc_link_monitor #(
  parameter int KICK_CYC = tfdc_pkg::KICK_CYC
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // link
  input wire logic [7:0] data_bus,
  input wire logic       delay_dac_write_strobe,
  input wire logic       slope_dac_write_strobe,
  input wire logic       control_latch_write_strobe,
  input wire logic       kicks_done_status
);
  localparam int K_HI = KICK_CYC + 2;
  logic kick_wr;
  logic done;
  assign kick_wr = control_latch_write_strobe && data_bus[tfdc_pkg::BIT_KICK];
  assign done    = kicks_done_status;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  property p_dly; delay_dac_write_strobe |=> !delay_dac_write_strobe; endproperty
  a_dly: assert property (p_dly)
    else $error("delay strobe too long");
  property p_slp; slope_dac_write_strobe |=> !slope_dac_write_strobe; endproperty
  a_slp: assert property (p_slp)
    else $error("slope strobe too long");
  property p_ctl; control_latch_write_strobe |=> !control_latch_write_strobe; endproperty
  a_ctl: assert property (p_ctl)
    else $error("control strobe too long");
  property p_one;
    $onehot0({delay_dac_write_strobe, slope_dac_write_strobe, control_latch_write_strobe});
  endproperty
  a_one: assert property (p_one)
    else $error("two strobes at once");
  property p_kdone; kick_wr && done |-> ##[1:3] !done; endproperty
  a_kdone: assert property (p_kdone)
    else $error("done did not drop on kick");
  property p_cause;
    $fell(done) |-> $past(kick_wr, 1) || $past(kick_wr, 2) || $past(kick_wr, 3);
  endproperty
  a_cause: assert property (p_cause)
    else $error("done dropped without kick");
  property p_hold; $fell(done) |=> !done [*3]; endproperty
  a_hold: assert property (p_hold)
    else $error("kick sequence too short");
  property p_width;
    kick_wr |-> ##[KICK_CYC:K_HI]
      (control_latch_write_strobe && !data_bus[tfdc_pkg::BIT_KICK]);
  endproperty
  a_width: assert property (p_width)
    else $error("kick pulse width wrong");
  property p_single; kick_wr |=> !kick_wr [*4]; endproperty
  a_single: assert property (p_single)
    else $error("kick trigger repeated");
  c_kick: cover property (kick_wr);
  c_fall: cover property ($fell(done));
  c_dly: cover property (delay_dac_write_strobe);
endmodule : tfdc_link_monitor
`default_nettype wire

// >>> tb_tuned_filter_driver_control.sv
// tb_tuned_filter_driver_control: host and device joined, random and corner tests
// assumes shortened kick, timeout and sequence counts
`timescale 1ns/10ps
`default_nettype none
module tb_tuned_filter_driver_control;
  localparam int unsigned SEQ = 8;
  localparam int unsigned KC  = 4;
  logic       clk   = 1'b0;
  logic       rst   = 1'b1;
  logic [3:0] addr  = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       sweep = 1'b0;
  logic [2:0] band  = 3'h0;
  logic       osc_n = 1'b1;
  logic [7:0] rdata, dly_w, slp_w, taps, v, d, s, c;
  logic       en, dres, park, zp, hp, hsel, smp, kick_n, kst;
  int         n_mismatch = 0;
  int         n_tests    = 0;
  int         cyc        = 0;
  int         n_kick, n_low, n_slo, i;
  always #25 clk = ~clk;
  tfdc_if lnk ();
  tfdc_device #(.SEQ_CYC(SEQ)) tfdc_device_i (.clk(clk), .rst(rst), .bus(lnk.device),
    .sweep_active(sweep), .band_code(band), .oscillator_kick_active_n(osc_n),
    .delay_dac_word(dly_w), .slope_dac_word(slp_w), .delay_comp_enable(en),
    .delay_comp_reset(dres), .divider_tap_sel(taps), .band_zero_park(park),
    .band_zero_path(zp), .band_high_path(hp), .hold_path_select(hsel),
    .track_sample(smp), .multiplier_kick_active_n(kick_n), .kick_start(kst));
  tfdc_host #(.KICK_CYC(KC), .TIMEOUT_CYC(50)) tfdc_host_i (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus(lnk.host));
  tfdc_link_monitor #(.KICK_CYC(KC)) tfdc_link_monitor_i (.clk(clk), .rst(rst),
    .data_bus(lnk.data_bus), .delay_dac_write_strobe(lnk.delay_dac_write_strobe),
    .slope_dac_write_strobe(lnk.slope_dac_write_strobe),
    .control_latch_write_strobe(lnk.control_latch_write_strobe),
    .kicks_done_status(lnk.kicks_done_status));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] tap_exp(input int b);
    return 8'h01 << b;
  endfunction : tap_exp
  function automatic logic [7:0] st_exp(input logic dn, input logic f);
    return {5'h00, dn, f, 1'b0};
  endfunction : st_exp
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] dat);
    @(posedge clk);
    addr <= a; wdata <= dat; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] dat);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 dat = rdata;
  endtask : rd_reg
  // second trigger lands while busy and must be ignored
  task automatic kick(input logic lo, input logic [7:0] exp);
    int k;
    n_kick = 0; n_low = 0; n_slo = 0;
    wr_reg(tfdc_pkg::A_KICK, 8'($urandom));
    osc_n <= ~lo;
    wr_reg(tfdc_pkg::A_KICK, 8'h00);
    v = 8'h01;
    for (k = 0; k < 100 && v[0] !== 1'b0; k++) rd_reg(tfdc_pkg::A_STATUS, v);
    check(v, exp);
    check(8'(n_kick), 8'h01);
    check({7'h00, n_low >= SEQ && n_low <= SEQ + 2}, 8'h01);
    check({7'h00, n_slo + 2 >= n_low}, 8'h01);
    $display("test kick done");
  endtask : kick
  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc++;
    if (kst === 1'b1) n_kick++;
    if (kick_n === 1'b0) n_low++;
    if (kick_n === 1'b0 && smp === 1'b0) n_slo++;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(71));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_n(6);
    rd_reg(tfdc_pkg::A_STATUS, v);
    check(v, st_exp(1'b1, 1'b0));
    rd_reg(tfdc_pkg::A_BAND, v);
    check(v, 8'h00);
    for (i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hff : 8'($urandom);
      s = (i == 7) ? 8'h00 : 8'($urandom);
      c = 8'($urandom) & 8'h18;
      wr_reg(tfdc_pkg::A_DELAY, d);
      wr_reg(tfdc_pkg::A_SLOPE, s);
      band <= 3'(i);
      sweep <= i[0];
      // slope word lands on the edge after the strobe, look one edge later
      wait_n(2);
      check(dly_w, d);
      check(slp_w, s);
      wr_reg(tfdc_pkg::A_CTRL, c);
      wait_n(6);
      check(taps, tap_exp(i));
      check({7'h00, park}, {7'h00, i == 0});
      check({6'h00, zp, hp}, (i == 0) ? 8'h02 : 8'h01);
      check({6'h00, en, dres}, i[0] ? 8'h02 : 8'h01);
      check({7'h00, hsel}, {7'h00, c[4]});
      check({7'h00, smp}, {7'h00, c[3]});
    end
    $display("test latches and decode done");
    wr_reg(tfdc_pkg::A_CTRL, 8'h08);
    wait_n(4);
    check({7'h00, smp}, 8'h01);
    rd_reg(tfdc_pkg::A_CTRL, v);
    check(v, 8'h08);
    kick(1'b0, st_exp(1'b1, 1'b0));
    kick(1'b1, st_exp(1'b0, 1'b1));
    check({7'h00, lnk.kicks_done_status}, 8'h00);
    osc_n <= 1'b1;
    wait_n(8);
    check({7'h00, lnk.kicks_done_status}, 8'h01);
    kick(1'b0, st_exp(1'b1, 1'b0));
    test_done();
  end
endmodule : tb_tuned_filter_driver_control
`default_nettype wire
